//--- logic/multi_io_fast_read_handler.sv
// quad output and dual i/o fast read sequencer of a serial flash, sdr and dtr forms
// assumes i_sck, i_cs_n and i_io synchronous to i_sys_clk and much slower than it;
// the array answers a byte request with i_arr_valid a few cycles later
// How it works
// - quad output read returns four bits per clock
// - quad output read needs quad_lines_permit set
// - quad output read waits eight dummy clocks
// - quad output 32-bit opcode always takes 32 bits
// - quad output 32-bit opcode rejected in four-line mode
// - dual i/o read: address and data two bits
// - dual i/o read waits four dummy clocks
// - eight continuation_mode_bits follow the address
// - code_skip_field 10 skips next instruction code
// - other code_skip_field values expect instruction code
// - dtr dual i/o uses io0 and io1
// - dual i/o 32-bit opcode always takes 32 bits
// - dual i/o 32-bit opcode single-line mode only
// - four-byte mode widens dual i/o addresses
// - reads are ignored while busy
// - dtr moves address and data both edges
// - address advances after every byte
// - data out on fall, code in on rise
`timescale 1ns/1ps
`default_nettype none
`include "mior_cfg.svh"

module multi_io_fast_read_handler
  import mior_pkg::*;
#(
  parameter int FIFO_WIDTH = `FIFO_WIDTH,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic [3:0]  i_io,
  output logic      [3:0]  o_io,
  output logic      [3:0]  o_io_oe,
  input  wire logic        i_quad_lines_permit,
  input  wire logic        i_busy,
  input  wire logic        i_addr4_mode,
  input  wire logic        i_qpi_mode,
  output logic             o_arr_req,
  output logic      [31:0] o_arr_addr,
  input  wire logic        i_arr_valid,
  input  wire logic [7:0]  i_arr_data,
  output logic             o_frame_active,
  output logic             o_skip_armed
);

  rd_state_e   state_q, state_d;
  rd_cfg_s     cfg_q, cfg_d, dec;
  io_drive_s   io_q, io_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [31:0] shin_q, shin_d;
  logic [7:0]  mode_q, mode_d, sr_q, sr_d, cur;
  logic [2:0]  mcnt_q, mcnt_d;
  logic [3:0]  left_q, left_d;
  logic        skip_q, skip_d, sck_q, rise, fall, smp_edge, drv_edge;
  logic [7:0]  skip_op_q, skip_op_d;
  logic        pop, fetch_start, fetching, push;
  logic        fifo_in_ready, fifo_valid;
  logic [7:0]  fifo_data;
  logic [31:0] fa_q, fa_d;
  logic        req_q, req_d, pend_q, pend_d;
  logic        active_q;

  ////////////////////////////////////////////////////////////////////////////////
  // instruction decode; every handled code is single-line-mode only
  function automatic rd_cfg_s decode_op(input logic [7:0] op, input logic a4,
                                        input logic qpi, input logic permit);
    rd_cfg_s c;
    c           = '0;
    c.op        = op;
    c.addr_bits = a4 ? `ADDR_BITS_4B : `ADDR_BITS_3B;
    case (op)
      `OP_QUAD_OUT: begin
        c.ok       = permit;
        c.quad_out = 1'b1;
        c.dummy    = `QUAD_OUT_DUMMY;
      end
      `OP_QUAD_OUT_A32: begin
        c.ok        = permit;
        c.quad_out  = 1'b1;
        c.dummy     = `QUAD_OUT_DUMMY;
        c.addr_bits = `ADDR_BITS_4B;
      end
      `OP_DUAL_IO: begin
        c.ok       = 1'b1;
        c.dual_in  = 1'b1;
        c.has_mode = 1'b1;
        c.dummy    = `DUAL_IO_DUMMY;
      end
      `OP_DUAL_IO_A32: begin
        c.ok        = 1'b1;
        c.dual_in   = 1'b1;
        c.has_mode  = 1'b1;
        c.dummy     = `DUAL_IO_DUMMY;
        c.addr_bits = `ADDR_BITS_4B;
      end
      `OP_DTR_DUAL_IO: begin
        c.ok       = 1'b1;
        c.dual_in  = 1'b1;
        c.has_mode = 1'b1;
        c.dtr      = 1'b1;
        c.dummy    = `DTR_DUAL_IO_DUMMY;
      end
      default: begin
        c.ok = 1'b0;
      end
    endcase
    if (qpi) begin
      c.ok = 1'b0;
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // clock edge detection on the sampled serial clock
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= i_sck;
    end
  end

  assign rise = i_sck && !sck_q;
  assign fall = !i_sck && sck_q;

  ////////////////////////////////////////////////////////////////////////////////
  // frame sequencer: instruction, address, dummy with mode capture, data out
  always_comb begin
    state_d     = state_q;
    cfg_d       = cfg_q;
    io_d        = io_q;
    cnt_d       = cnt_q;
    shin_d      = shin_q;
    mode_d      = mode_q;
    mcnt_d      = mcnt_q;
    sr_d        = sr_q;
    left_d      = left_q;
    skip_d      = skip_q;
    skip_op_d   = skip_op_q;
    pop         = 1'b0;
    fetch_start = 1'b0;
    cur         = sr_q;
    dec         = decode_op(skip_op_q, i_addr4_mode, i_qpi_mode, i_quad_lines_permit);
    smp_edge    = rise || (fall && cfg_q.dtr);
    drv_edge    = fall || (rise && cfg_q.dtr);
    if (i_cs_n) begin
      state_d = ST_IDLE;
      io_d    = '0;
      cfg_d   = '0;
      if (state_q != ST_IDLE) begin
        // ones on io0 set the low field bit, so the field never reads 10 and the host escape always lands here
        skip_d    = cfg_q.has_mode && (mcnt_q == `MODE_SAMPLES) &&
                    (mode_q[`SKIP_FIELD_HI:`SKIP_FIELD_LO] == `SKIP_FIELD_CODE);
        skip_op_d = cfg_q.op;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_d  = '0;
          shin_d = '0;
          mode_d = '0;
          mcnt_d = '0;
          left_d = '0;
          if (skip_q) begin
            cfg_d   = dec;
            state_d = (dec.ok && !i_busy) ? ST_ADDR : ST_IGNORE;
          end else begin
            state_d = ST_CMD;
          end
        end
        ST_CMD: begin
          if (rise) begin
            shin_d = {shin_q[30:0], i_io[0]};
            cnt_d  = cnt_q + 6'h01;
            if (cnt_q == `CMD_BITS - 6'h01) begin
              dec     = decode_op({shin_q[6:0], i_io[0]}, i_addr4_mode, i_qpi_mode,
                                  i_quad_lines_permit);
              cfg_d   = dec;
              cnt_d   = '0;
              shin_d  = '0;
              state_d = (dec.ok && !i_busy) ? ST_ADDR : ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          // the fall that closes the instruction byte is not an address edge
          if (smp_edge && (rise || cnt_q != 6'h00)) begin
            if (cfg_q.dual_in) begin
              shin_d = {shin_q[29:0], i_io[1], i_io[0]};
              cnt_d  = cnt_q + 6'h02;
            end else begin
              shin_d = {shin_q[30:0], i_io[0]};
              cnt_d  = cnt_q + 6'h01;
            end
            if (cnt_d == cfg_q.addr_bits) begin
              cnt_d       = '0;
              fetch_start = 1'b1;
              state_d     = ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          // continuation byte rides on the first dummy clocks; dummy input is otherwise unused
          if (cfg_q.has_mode && smp_edge && (mcnt_q != `MODE_SAMPLES)) begin
            mode_d = {mode_q[5:0], i_io[1], i_io[0]};
            mcnt_d = mcnt_q + 3'h1;
          end
          if (rise) begin
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == {1'b0, cfg_q.dummy} - 6'h01) begin
              state_d = ST_DATA;
              left_d  = '0;
            end
          end
        end
        ST_DATA: begin
          if (drv_edge) begin
            if (left_q == 4'h0) begin
              cur = fifo_valid ? fifo_data : `UNDERRUN_BYTE;
              pop = fifo_valid;
            end
            // host has let go of the lines before this edge
            if (cfg_q.quad_out) begin
              io_d.dout = cur[7:4];
              io_d.oe   = 4'hF;
              sr_d      = {cur[3:0], 4'h0};
              left_d    = (left_q == 4'h0) ? 4'h4 : left_q - 4'h4;
            end else begin
              io_d.dout = {2'b00, cur[7:6]};
              io_d.oe   = 4'h3;
              sr_d      = {cur[5:0], 2'b00};
              left_d    = (left_q == 4'h0) ? 4'h6 : left_q - 4'h2;
            end
          end
        end
        ST_IGNORE: begin
          state_d = ST_IGNORE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q   <= ST_IDLE;
      cfg_q     <= '0;
      io_q      <= '0;
      cnt_q     <= '0;
      shin_q    <= `RST_ADDR;
      mode_q    <= `RST_BYTE;
      mcnt_q    <= '0;
      sr_q      <= `RST_BYTE;
      left_q    <= '0;
      skip_q    <= 1'b0;
      skip_op_q <= `RST_BYTE;
      active_q  <= 1'b0;
    end else begin
      state_q   <= state_d;
      cfg_q     <= cfg_d;
      io_q      <= io_d;
      cnt_q     <= cnt_d;
      shin_q    <= shin_d;
      mode_q    <= mode_d;
      mcnt_q    <= mcnt_d;
      sr_q      <= sr_d;
      left_q    <= left_d;
      skip_q    <= skip_d;
      skip_op_q <= skip_op_d;
      active_q  <= (state_d != ST_IDLE) && (state_d != ST_IGNORE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array prefetch: one request in flight, stalled by a full buffer
  assign fetching = (state_q == ST_DUMMY) || (state_q == ST_DATA);
  assign push     = i_arr_valid && pend_q && fetching;

  always_comb begin
    fa_d   = fa_q;
    req_d  = 1'b0;
    pend_d = pend_q;
    if (i_arr_valid) begin
      pend_d = 1'b0;
      fa_d   = fa_q + 32'h1;
    end
    if (fetch_start) begin
      fa_d = shin_d;
    end else if (fetching && !i_cs_n && !pend_q && !req_q && fifo_in_ready) begin
      req_d  = 1'b1;
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fa_q   <= `RST_ADDR;
      req_q  <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      fa_q   <= fa_d;
      req_q  <= req_d;
      pend_q <= pend_d;
    end
  end

  // stale prefetch is dropped when chip select rises
  read_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_resetn    (i_resetn),
    .i_flush     (i_cs_n),
    .i_in_valid  (push),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_arr_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_data)
  );

  assign o_io           = io_q.dout;
  assign o_io_oe        = io_q.oe;
  assign o_arr_req      = req_q;
  assign o_arr_addr     = fa_q;
  assign o_frame_active = active_q;
  assign o_skip_armed   = skip_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks; helper remembers the previous request address of this frame
  logic [31:0] prev_req_q;
  logic        req_seen_q;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_req_q <= '0;
      req_seen_q <= 1'b0;
    end else begin
      prev_req_q <= req_q ? fa_q : prev_req_q;
      req_seen_q <= fetch_start ? 1'b0 : (req_seen_q || req_q);
    end
  end

  a_lines_only_data: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_io_oe != 4'h0) |-> (state_q == ST_DATA))
    else $error("io driven outside data phase");
  a_quad_all_lanes: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_io_oe != 4'h0 && cfg_q.quad_out) |-> (o_io_oe == 4'hF))
    else $error("quad read not on four lines");
  a_dual_two_lanes: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_io_oe != 4'h0 && !cfg_q.quad_out) |-> (o_io_oe == 4'h3))
    else $error("dual read not on two lines");
  a_quad_needs_permit: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == ST_ADDR && $past(state_q) == ST_CMD && cfg_q.quad_out)
      |-> $past(i_quad_lines_permit))
    else $error("quad read accepted without permit");
  a_busy_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == ST_CMD && rise && cnt_q == 6'h07 && i_busy && !i_cs_n)
      |=> (state_q == ST_IGNORE))
    else $error("read taken while busy");
  a_skip_starts_addr: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == ST_IDLE && !i_cs_n && skip_q && !i_busy && !i_qpi_mode)
      |=> (state_q == ST_ADDR))
    else $error("armed frame did not start at address");
  a_skip_from_field: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (i_cs_n && state_q != ST_IDLE) |=>
      (skip_q == ($past(cfg_q.has_mode) && $past(mcnt_q) == 3'h4 &&
                  $past(mode_q[5:4]) == 2'b10)))
    else $error("skip flag does not follow the mode field");
  a_dummy_then_data: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ($past(state_q) == ST_DUMMY && state_q == ST_DATA && !i_cs_n)
      |-> (cnt_q == {1'b0, cfg_q.dummy}))
    else $error("wrong dummy clock count");
  a_wide_addr: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == ST_ADDR && (cfg_q.op == 8'h6C || cfg_q.op == 8'hBC))
      |-> (cfg_q.addr_bits == 6'h20))
    else $error("32-bit opcode without 32 address bits");
  a_no_qpi_accept: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_q == ST_CMD && rise && cnt_q == 6'h07 && i_qpi_mode && !i_cs_n)
      |=> (state_q == ST_IGNORE))
    else $error("read accepted in four-line mode");
  a_fetch_step: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (req_q && req_seen_q) |-> (fa_q == prev_req_q + 32'h1))
    else $error("prefetch address did not advance by one");
  a_out_on_edge: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_io != $past(o_io) && o_io_oe != 4'h0 && $past(o_io_oe) != 4'h0)
      |-> ($past(fall) || ($past(rise) && cfg_q.dtr)))
    else $error("data changed off a drive edge");

endmodule

`default_nettype wire

//--- logic/mior_cfg.svh
// constants of the multi-line fast read handler: opcodes, counts, field positions
// assumes nothing; included by the principal module only
`ifndef MIOR_CFG_SVH
`define MIOR_CFG_SVH

// instruction codes handled here
`define OP_QUAD_OUT        8'h6B
`define OP_QUAD_OUT_A32    8'h6C
`define OP_DUAL_IO         8'hBB
`define OP_DUAL_IO_A32     8'hBC
`define OP_DTR_DUAL_IO     8'hBD

// dummy clocks between the last address bit and the first data clock
`define QUAD_OUT_DUMMY     5'h08
`define DUAL_IO_DUMMY      5'h04
`define DTR_DUAL_IO_DUMMY  5'h04

// address widths in bits
`define ADDR_BITS_3B       6'h18
`define ADDR_BITS_4B       6'h20

// instruction phase length and continuation byte layout
`define CMD_BITS           6'h08
`define MODE_SAMPLES       3'h4
`define SKIP_FIELD_HI      5
`define SKIP_FIELD_LO      4
`define SKIP_FIELD_CODE    2'h2

// read buffer shape and the byte sent when it runs dry
`define FIFO_DEPTH         32
`define FIFO_WIDTH         8
`define UNDERRUN_BYTE      8'hFF

// reset values
`define RST_BYTE           8'h00
`define RST_ADDR           32'h0000_0000

`endif

//--- logic/mior_pkg.sv
// types of the fast read handler; its buffer and storage use none of them
// assumes mior_cfg.svh on the include path
package mior_pkg;

  // frame sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_CMD    = 6'h02,
    ST_ADDR   = 6'h04,
    ST_DUMMY  = 6'h08,
    ST_DATA   = 6'h10,
    ST_IGNORE = 6'h20
  } rd_state_e;

  // decoded shape of one read instruction
  typedef struct packed {
    logic       ok;
    logic [7:0] op;
    logic       dual_in;
    logic       quad_out;
    logic       dtr;
    logic       has_mode;
    logic [5:0] addr_bits;
    logic [4:0] dummy;
  } rd_cfg_s;

  // what the IO pins are driven with
  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe;
  } io_drive_s;

endpackage

//--- logic/fifo_mem.sv
// small dual-port storage for the read buffer
// assumes one clock; read data come from a register one cycle after i_rd_en
`timescale 1ns/1ps
`default_nettype none

module fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_addr,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_rd_en,
  input  wire logic [AW-1:0]    i_rd_addr,
  output logic      [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // array itself carries no reset, so it maps onto plain ram cells
  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  // registered read port
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_q <= '0;
    end else if (i_rd_en) begin
      rd_q <= mem_q[i_rd_addr];
    end
  end

  assign o_rd_data = rd_q;

endmodule

`default_nettype wire

//--- logic/read_fifo.sv
// read data buffer: valid/ready on both sides, one output holding stage
// assumes one clock; i_flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none

module read_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic        ov_q, ov_d, pend_q, pend_d;
  logic        full, empty, wr_en, rd_en;

  ////////////////////////////////////////////////////////////////////////////////
  // pointers carry one extra bit so full and empty are told apart
  always_comb begin
    full   = (wp_q - rp_q) == FULL_CNT;
    empty  = (wp_q == rp_q);
    wr_en  = i_in_valid && !full;
    // refill the holding stage only when it is free; costs two idle cycles per word
    rd_en  = !empty && !ov_q && !pend_q && !i_flush;
    wp_d   = wp_q;
    rp_d   = rp_q;
    ov_d   = ov_q;
    pend_d = rd_en;
    if (wr_en) begin
      wp_d = wp_q + 1'b1;
    end
    if (rd_en) begin
      rp_d = rp_q + 1'b1;
    end
    if (pend_q) begin
      ov_d = 1'b1;
    end else if (ov_q && i_out_ready) begin
      ov_d = 1'b0;
    end
    if (i_flush) begin
      wp_d   = '0;
      rp_d   = '0;
      ov_d   = 1'b0;
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_q   <= '0;
      rp_q   <= '0;
      ov_q   <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      ov_q   <= ov_d;
      pend_q <= pend_d;
    end
  end

  fifo_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_wr_en   (wr_en && !i_flush),
    .i_wr_addr (wp_q[AW-1:0]),
    .i_wr_data (i_in_data),
    .i_rd_en   (rd_en),
    .i_rd_addr (rp_q[AW-1:0]),
    .o_rd_data (o_out_data)
  );

  assign o_in_ready  = !full;
  assign o_out_valid = ov_q;

endmodule

`default_nettype wire

//--- tb/spi_host_model.sv
// host controller model: drives chip select, serial clock and the io lines
// assumes i_sys_clk is the bench clock; tasks are called from the bench at a rising edge
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic [3:0] i_io,
  output logic            o_cs_n,
  output logic            o_sck,
  output logic      [3:0] o_io
);
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_io   = 4'h0;
  end

  task automatic wt(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask

  // select falls well ahead of the first clock rise; the clock stands low between frames
  task automatic open_frame();
    o_cs_n <= 1'b0;
    wt(4);
  endtask

  task automatic close_frame();
    o_cs_n <= 1'b1;
    o_sck  <= 1'b0; // clock parks low so the next frame opens on a rise
    o_io   <= ~o_io;
    wt(4);
  endtask

  // n bits of v msb first, w lines a group, io1 high bit; dtr moves a group on each edge
  task automatic send(input logic [31:0] v, input int n, input int w, input bit dtr);
    logic [31:0] s;
    for (int i = n - w; i >= 0; i -= w) begin
      s = v >> i;
      o_io <= (w == 1) ? {3'h0, s[0]} : {2'h0, s[1:0]};
      wt(4);
      if (dtr) begin
        o_sck <= ~o_sck;
        wt(4); // group holds past the capture of this edge
      end else begin
        o_sck <= 1'b1;
        wt(2);
        o_io  <= ~o_io; // lines let go after the capture edge, never held stale
        wt(2);
        o_sck <= 1'b0;
      end
    end
  endtask

  // n groups of w bits, sampled once each drive edge has settled
  task automatic recv(input int n, input int w, input bit dtr, output logic [15:0] got);
    got = 16'h0000;
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        o_sck <= dtr ? ~o_sck : 1'b1;
        if (!dtr) begin
          wt(4);
          o_sck <= 1'b0;
        end
      end
      wt(4);
      got = (got << w) | {12'h000, i_io & ((w == 4) ? 4'hF : 4'h3)};
    end
  endtask
endmodule

`default_nettype wire

//--- tb/multi_io_fast_read_handler_test.sv
// self-checking bench of the multi-line fast read handler
// assumes the host model compiled first; the array answers two cycles after a request
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module multi_io_fast_read_handler_test;
  logic        i_sys_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_quad_lines_permit = 1'b0;
  logic        i_busy = 1'b0;
  logic        i_addr4_mode = 1'b0;
  logic        i_qpi_mode = 1'b0;
  logic        i_arr_valid = 1'b0;
  logic        req_q = 1'b0;
  logic [7:0]  i_arr_data = 8'h00;
  logic        cs_n, sck, o_arr_req, o_frame_active, o_skip_armed, act;
  logic [3:0]  host_io, o_io, o_io_oe;
  logic [7:0]  op;
  logic [31:0] o_arr_addr, addr_q;
  logic [15:0] got, exp;
  int          n_fail = 0;
  int          n_checks = 0;
  // opcode, permit, four-line mode, busy, expected frame acceptance
  logic [11:0] rows [7] = '{{8'h6B, 4'h9}, {8'h6B, 4'h0}, {8'h6C, 4'hC}, {8'hBC, 4'h4},
                            {8'hBB, 4'h2}, {8'hBD, 4'h1}, {8'h6C, 4'h9}};

  always #5 i_sys_clk = ~i_sys_clk;

  multi_io_fast_read_handler dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cs_n(cs_n),
    .i_sck(sck), .i_io(host_io), .o_io(o_io), .o_io_oe(o_io_oe),
    .i_quad_lines_permit(i_quad_lines_permit), .i_busy(i_busy), .i_addr4_mode(i_addr4_mode),
    .i_qpi_mode(i_qpi_mode), .o_arr_req(o_arr_req), .o_arr_addr(o_arr_addr),
    .i_arr_valid(i_arr_valid), .i_arr_data(i_arr_data), .o_frame_active(o_frame_active),
    .o_skip_armed(o_skip_armed));
  spi_host_model host (.i_sys_clk(i_sys_clk), .i_io(o_io), .o_cs_n(cs_n), .o_sck(sck),
    .o_io(host_io));

  // byte mixes top and bottom address bytes so a lost upper byte shows
  function automatic logic [7:0] arr_byte(input logic [31:0] a);
    return a[7:0] ^ a[31:24];
  endfunction

  // array model with a fixed two-cycle answer
  always @(posedge i_sys_clk) begin
    req_q       <= o_arr_req;
    addr_q      <= o_arr_addr;
    i_arr_valid <= req_q;
    i_arr_data  <= arr_byte(addr_q);
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one read of two bytes; mode bits fill the first dummy clocks of dual reads
  task automatic rd(input logic [7:0] c, input bit skip, input logic [31:0] a, input int nab,
                    input bit dual, input bit dtr, input logic [7:0] mode);
    host.open_frame();
    if (!skip) host.send({24'h0, c}, 8, 1, 1'b0);
    host.send(a, nab, dual ? 2 : 1, dtr);
    if (dual) host.send({24'h0, mode}, 8, 2, dtr);
    if (dtr) host.send(32'h96, 8, 2, 1'b1);
    if (!dual) host.send(32'hA5, 8, 1, 1'b0);
    host.recv(dual ? 8 : 4, dual ? 2 : 4, dtr, got);
    exp = {arr_byte(a), arr_byte(a + 32'h1)};
  endtask

  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    `CHK("reset outs", 11'h000, {o_io, o_io_oe, o_arr_req, o_frame_active, o_skip_armed})
    @(posedge i_sys_clk);
    // acceptance table
    foreach (rows[k]) begin
      {op, i_quad_lines_permit, i_qpi_mode, i_busy, act} <= rows[k];
      host.open_frame();
      host.send({24'h0, op}, 8, 1, 1'b0);
      host.wt(4);
      `CHK("frame active", act, o_frame_active)
      host.close_frame();
    end
    {i_quad_lines_permit, i_qpi_mode, i_busy} <= 3'h4;
    rd(8'h6C, 1'b0, 32'h5A00_0013, 32, 1'b0, 1'b0, 8'h00);
    `CHK("quad data", exp, got)
    `CHK("quad oe", 4'hF, o_io_oe)
    host.close_frame();
    rd(8'hBB, 1'b0, 32'h0000_2040, 24, 1'b1, 1'b0, 8'h25);
    `CHK("dual data", exp, got)
    `CHK("dual oe", 4'h3, o_io_oe)
    host.close_frame();
    `CHK("skip armed", 1'b1, o_skip_armed)
    // code left out; wider address from four-byte mode; ones on the mode bits end it
    i_addr4_mode <= 1'b1;
    rd(8'hBB, 1'b1, 32'h3300_0101, 32, 1'b1, 1'b0, 8'hFF);
    `CHK("skip data", exp, got)
    host.close_frame();
    `CHK("skip ended", 1'b0, o_skip_armed)
    i_addr4_mode <= 1'b0;
    rd(8'hBC, 1'b0, 32'hC300_0000, 32, 1'b1, 1'b0, 8'h00);
    `CHK("dual a32 data", exp, got)
    host.close_frame();
    rd(8'hBD, 1'b0, 32'h0011_22FF, 24, 1'b1, 1'b1, 8'h20);
    `CHK("dtr data", exp, got)
    `CHK("dtr oe", 4'h3, o_io_oe)
    host.close_frame();
    `CHK("dtr skip", 1'b1, o_skip_armed)
    // code left out again; io0 held high through the low three address bytes and the mode to leave the mode
    rd(8'hBD, 1'b1, 32'h0055_5555, 24, 1'b1, 1'b1, 8'hFF);
    `CHK("dtr skip data", exp, got)
    host.close_frame();
    `CHK("dtr skip ended", 1'b0, o_skip_armed)
    close_out();
  end
endmodule

`default_nettype wire
